// file: shared/cpec_params.svh
// Constants of the event counter: offsets, fields, resets, answers
// Assumes inclusion by bare name from design and bench files
`ifndef CPEC_PARAMS_SVH
`define CPEC_PARAMS_SVH

// ==========================================
// Register byte offsets
`define CPEC_OFF_CTRL 8'h00
`define CPEC_OFF_STAT 8'h04
`define CPEC_OFF_SEL0 8'h08
`define CPEC_OFF_SEL1 8'h0c
`define CPEC_OFF_CNT0 8'h10
`define CPEC_OFF_CNT1 8'h14

// ==========================================
// Field positions
`define CPEC_CTRL_RUN   0
`define CPEC_CTRL_CLR   1
`define CPEC_STAT_RUN   0
`define CPEC_STAT_WRAP0 1
`define CPEC_STAT_WRAP1 2

// ==========================================
// Reset values and bus answers
`define CPEC_SEL_RST     5'h1f
`define CPEC_CNT_RST     32'h0000_0000
`define CPEC_RESP_OKAY   2'h0
`define CPEC_RESP_SLVERR 2'h2

`endif

// file: shared/cpec_pkg.sv
// Types of the event counter: event codes and bus state machines
// Assumes nothing beyond a SystemVerilog compiler
package cpec_pkg;

	// ==========================================
	// Event selection codes, one bit each in the event vector
	typedef enum logic [4:0] {
		CACHED_OPERAND_READ_EVT   = 5'h00,
		CACHED_OPERAND_WRITE_EVT  = 5'h01,
		CACHED_OPERAND_RW_EVT     = 5'h02,
		ONCHIP_RAM_ACCESS_EVT     = 5'h03,
		ANY_OPERAND_ACCESS_EVT    = 5'h04,
		PERIPH_REGION_ACCESS_EVT  = 5'h05,
		DATA_CACHE_READ_MISS_EVT  = 5'h06,
		DATA_CACHE_WRITE_MISS_EVT = 5'h07,
		DATA_CACHE_ANY_MISS_EVT   = 5'h08,
		ICACHE_MISS_EVT           = 5'h09,
		DATA_XLATE_MISS_EVT       = 5'h0a,
		INSTR_XLATE_MISS_EVT      = 5'h0b,
		CACHED_FETCH_EVT          = 5'h0c,
		ANY_FETCH_EVT             = 5'h0d,
		BRANCH_ISSUE_EVT          = 5'h0e,
		BRANCH_TAKEN_EVT          = 5'h0f,
		CALL_ISSUE_EVT            = 5'h10,
		INSTR_ISSUE_EVT           = 5'h11,
		DUAL_ISSUE_EVT            = 5'h12,
		FLOAT_ISSUE_EVT           = 5'h13,
		TRAP_EXEC_EVT             = 5'h14,
		INTERRUPT_EVT             = 5'h15,
		NMI_EVT                   = 5'h16,
		BREAK_CHAN_FIRST_EVT      = 5'h17,
		BREAK_CHAN_SECOND_EVT     = 5'h18,
		ICACHE_FILL_CYCLES        = 5'h19,
		DCACHE_FILL_CYCLES        = 5'h1a,
		ELAPSED_CYCLES            = 5'h1b,
		STALL_ICACHE_CYCLES       = 5'h1c,
		STALL_DCACHE_CYCLES       = 5'h1d,
		STALL_BRANCH_EXC_CYCLES   = 5'h1e,
		NO_EVT                    = 5'h1f
	} cpec_evt_e;

	// ==========================================
	// Bus state machines, one-hot
	typedef enum logic [1:0] {WR_COLLECT = 2'b01, WR_RESP = 2'b10} cpec_wr_e;
	typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} cpec_rd_e;
	typedef logic [31:0] cpec_word_t;

endpackage

// file: verilog/cpec_chan.sv
// One counting channel: picks one event bit and counts it
// Assumes event vector and controls come from logic on mclk
`include "cpec_params.svh"

module cpec_chan (
	// Clock, reset, enable
	input  wire logic              mclk,
	input  wire logic              rstn,
	input  wire logic              ce,
	// Event selection and control
	input  wire logic [31:0]       evtVec,
	input  wire cpec_pkg::cpec_evt_e sel,
	input  wire logic              run,
	input  wire logic              clr,
	// Count and wrap pulse
	output cpec_pkg::cpec_word_t   count_r,
	output logic                   wrapHit_r
);
	import cpec_pkg::*;

	cpec_word_t count_nxt;
	logic       wrapHit_nxt;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	// ==========================================
	// Counter: clear wins, else step while running
	always_comb begin
		count_nxt   = count_r;
		wrapHit_nxt = 1'b0;
		if (clr) begin
			count_nxt = `CPEC_CNT_RST;
		end else if (run && evtVec[sel]) begin
			count_nxt   = count_r + 32'h1;
			wrapHit_nxt = (count_r == 32'hffff_ffff);
		end
	end

	// Held while ce low, so a stalled bench loses nothing
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			count_r   <= `CPEC_CNT_RST;
			wrapHit_r <= 1'b0;
		end else if (ce) begin
			count_r   <= count_nxt;
			wrapHit_r <= wrapHit_nxt;
		end
	end

	// ==========================================
	// Checks
	a_cnt_step: assert property (
		ce && run && !clr && evtVec[sel] |=> count_r == $past(count_r) + 32'h1)
		else $error("Counter missed a qualifying event");
	a_cnt_hold: assert property (
		!run && !clr |=> $stable(count_r))
		else $error("Counter moved while stopped");
	a_cnt_clear: assert property (
		ce && clr |=> count_r == 32'h0)
		else $error("Counter not cleared");

endmodule

// file: verilog/cpec_top.sv
// Two-channel performance event counter with AXI4-Lite registers
// Assumes event strobes come from pipeline logic on mclk, unsynchronised
//
// How it works
// - Two channels, each with its own event select, count side by side
// - Cached operand accesses with cache on: reads, writes, or both
// - Events for on-chip RAM accesses and peripheral region accesses
// - One event counts every operand access whatever its area
// - Data cache misses on reads, on writes, or on either
// - One event counts each instruction cache miss
// - Unified translation misses on data accesses are their own event
// - Instruction-side translation misses of either buffer form one event
// - Cached fetches with cache on; separately every fetch of any kind
// - Branch issues counted, except non-delayed conditionals with zero displacement
// - Taken branches counted over the same set of branches
// - Each relative, register-relative or indirect call issue counts
// - Instruction issues counted; dual issues counted as separate event
// - Each floating-point instruction issue counts
// - Each software trap execution counts
// - Maskable interrupts one event, non-maskable interrupts another
// - First and second break-match channels each have an event
// - Instruction cache and data cache fill cycles each counted
// - Elapsed cycles count every clock with ce high while measuring
// - Stall cycles from instruction and data cache misses counted apart
// - Stall cycles from branches or exceptions form one event
`include "cpec_params.svh"

module cpec_top (
	// Clock, reset, enable
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        ce,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// AXI4-Lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output cpec_pkg::cpec_word_t rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Operand side strobes
	input  wire logic        cacheEnable,
	input  wire logic        opAccess,
	input  wire logic        opWrite,
	input  wire logic        opCacheable,
	input  wire logic        opOnchipRam,
	input  wire logic        opPeriph,
	input  wire logic        dcReadMiss,
	input  wire logic        dcWriteMiss,
	input  wire logic        dataXlateMiss,
	// Instruction side strobes
	input  wire logic        icacheMiss,
	input  wire logic        instrXlateMiss,
	input  wire logic        fetchAccept,
	input  wire logic        fetchCacheable,
	input  wire logic        branchIssue,
	input  wire logic        branchZeroDisp,
	input  wire logic        branchTaken,
	input  wire logic        callIssue,
	input  wire logic        instrIssue,
	input  wire logic        dualIssue,
	input  wire logic        floatIssue,
	input  wire logic        trapExec,
	// Interrupt and break strobes
	input  wire logic        irqAccept,
	input  wire logic        nmiAccept,
	input  wire logic        breakMatchFirst,
	input  wire logic        breakMatchSecond,
	// Cycle levels
	input  wire logic        icacheFill,
	input  wire logic        dcacheFill,
	input  wire logic        stallIcache,
	input  wire logic        stallDcache,
	input  wire logic        stallBranchExc,
	// Status
	output logic             measureActive
);
	import cpec_pkg::*;

	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_STAT = 3'h1;
	localparam logic [2:0] IDX_SEL0 = 3'h2;
	localparam logic [2:0] IDX_SEL1 = 3'h3;
	localparam logic [2:0] IDX_CNT0 = 3'h4;
	localparam logic [2:0] IDX_CNT1 = 3'h5;
	localparam logic [2:0] IDX_NONE = 3'h7;

	// Event stage
	logic [31:0] evt_r, evt_nxt;
	logic        cachedOp;
	// Write side and registers
	cpec_wr_e    wrSt_r, wrSt_nxt;
	logic        awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
	logic [7:0]  awAddr_r, awAddr_nxt;
	cpec_word_t  wData_r, wData_nxt;
	logic        wStrb0_r, wStrb0_nxt;
	logic        awready_r, awready_nxt, wready_r, wready_nxt;
	logic        bvalid_r, bvalid_nxt;
	logic [1:0]  bresp_r, bresp_nxt;
	logic        run_r, run_nxt, clr_r, clr_nxt;
	cpec_evt_e   sel0_r, sel0_nxt, sel1_r, sel1_nxt;
	logic [1:0]  wrap_r, wrap_nxt;
	// Read side
	cpec_rd_e    rdSt_r, rdSt_nxt;
	logic        arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	cpec_word_t  rdata_r, rdata_nxt;
	logic [1:0]  rresp_r, rresp_nxt;
	// Channels
	cpec_word_t  cnt0, cnt1;
	logic        wrapHit0, wrapHit1;

	// Aligned offset to register index; anything else is unmapped
	function automatic logic [2:0] regIndex(input logic [7:0] a);
		case (a)
			`CPEC_OFF_CTRL: regIndex = IDX_CTRL;
			`CPEC_OFF_STAT: regIndex = IDX_STAT;
			`CPEC_OFF_SEL0: regIndex = IDX_SEL0;
			`CPEC_OFF_SEL1: regIndex = IDX_SEL1;
			`CPEC_OFF_CNT0: regIndex = IDX_CNT0;
			`CPEC_OFF_CNT1: regIndex = IDX_CNT1;
			default:        regIndex = IDX_NONE;
		endcase
	endfunction

	// ==========================================
	// Event stage: qualify strobes into one vector
	// One register stage keeps the 32-way select off the pipeline paths
	always_comb begin
		cachedOp = opAccess && opCacheable && cacheEnable;
		evt_nxt  = 32'h0;
		evt_nxt[CACHED_OPERAND_READ_EVT]   = cachedOp && !opWrite;
		evt_nxt[CACHED_OPERAND_WRITE_EVT]  = cachedOp && opWrite;
		evt_nxt[CACHED_OPERAND_RW_EVT]     = cachedOp;
		evt_nxt[ONCHIP_RAM_ACCESS_EVT]     = opAccess && opOnchipRam;
		evt_nxt[PERIPH_REGION_ACCESS_EVT]  = opAccess && opPeriph;
		evt_nxt[ANY_OPERAND_ACCESS_EVT]    = opAccess;
		evt_nxt[DATA_CACHE_READ_MISS_EVT]  = dcReadMiss;
		evt_nxt[DATA_CACHE_WRITE_MISS_EVT] = dcWriteMiss;
		evt_nxt[DATA_CACHE_ANY_MISS_EVT]   = dcReadMiss || dcWriteMiss;
		evt_nxt[ICACHE_MISS_EVT]           = icacheMiss;
		evt_nxt[DATA_XLATE_MISS_EVT]       = dataXlateMiss;
		evt_nxt[INSTR_XLATE_MISS_EVT]      = instrXlateMiss;
		evt_nxt[CACHED_FETCH_EVT]          = fetchAccept && fetchCacheable && cacheEnable;
		evt_nxt[ANY_FETCH_EVT]             = fetchAccept;
		evt_nxt[BRANCH_ISSUE_EVT]          = branchIssue && !branchZeroDisp;
		evt_nxt[BRANCH_TAKEN_EVT]          = branchTaken && !branchZeroDisp;
		evt_nxt[CALL_ISSUE_EVT]            = callIssue;
		evt_nxt[INSTR_ISSUE_EVT]           = instrIssue;
		evt_nxt[DUAL_ISSUE_EVT]            = dualIssue;
		evt_nxt[FLOAT_ISSUE_EVT]           = floatIssue;
		evt_nxt[TRAP_EXEC_EVT]             = trapExec;
		evt_nxt[INTERRUPT_EVT]             = irqAccept;
		evt_nxt[NMI_EVT]                   = nmiAccept;
		evt_nxt[BREAK_CHAN_FIRST_EVT]      = breakMatchFirst;
		evt_nxt[BREAK_CHAN_SECOND_EVT]     = breakMatchSecond;
		evt_nxt[ICACHE_FILL_CYCLES]        = icacheFill;
		evt_nxt[DCACHE_FILL_CYCLES]        = dcacheFill;
		evt_nxt[ELAPSED_CYCLES]            = 1'b1;
		evt_nxt[STALL_ICACHE_CYCLES]       = stallIcache;
		evt_nxt[STALL_DCACHE_CYCLES]       = stallDcache;
		evt_nxt[STALL_BRANCH_EXC_CYCLES]   = stallBranchExc;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			evt_r <= 32'h0;
		end else if (ce) begin
			evt_r <= evt_nxt;
		end
	end

	// ==========================================
	// Write side: address and data taken in either order
	always_comb begin
		wrSt_nxt   = wrSt_r;
		awHeld_nxt = awHeld_r;
		wHeld_nxt  = wHeld_r;
		awAddr_nxt = awAddr_r;
		wData_nxt  = wData_r;
		wStrb0_nxt = wStrb0_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt  = bresp_r;
		run_nxt    = run_r;
		clr_nxt    = 1'b0;
		sel0_nxt   = sel0_r;
		sel1_nxt   = sel1_r;
		// Wrap flags: a new wrap beats a clear in the same cycle
		wrap_nxt   = wrap_r | {wrapHit1, wrapHit0};
		case (wrSt_r)
			WR_COLLECT: begin
				if (awvalid && awready_r) begin
					awHeld_nxt = 1'b1;
					awAddr_nxt = awaddr;
				end
				if (wvalid && wready_r) begin
					wHeld_nxt  = 1'b1;
					wData_nxt  = wdata;
					wStrb0_nxt = wstrb[0];
				end
				if (awHeld_r && wHeld_r) begin
					awHeld_nxt = 1'b0;
					wHeld_nxt  = 1'b0;
					bvalid_nxt = 1'b1;
					bresp_nxt  = `CPEC_RESP_OKAY;
					wrSt_nxt   = WR_RESP;
					// All fields sit in byte 0; other lanes are ignored
					case (regIndex(awAddr_r))
						IDX_CTRL: begin
							if (wStrb0_r) begin
								run_nxt = wData_r[`CPEC_CTRL_RUN];
								clr_nxt = wData_r[`CPEC_CTRL_CLR];
							end
						end
						IDX_STAT: begin
							if (wStrb0_r) begin
								wrap_nxt = (wrap_r & ~wData_r[`CPEC_STAT_WRAP1:`CPEC_STAT_WRAP0])
									| {wrapHit1, wrapHit0};
							end
						end
						IDX_SEL0: begin
							if (wStrb0_r) begin
								sel0_nxt = cpec_evt_e'(wData_r[4:0]);
							end
						end
						IDX_SEL1: begin
							if (wStrb0_r) begin
								sel1_nxt = cpec_evt_e'(wData_r[4:0]);
							end
						end
						IDX_CNT0, IDX_CNT1: begin
							bresp_nxt = `CPEC_RESP_OKAY;
						end
						default: begin
							bresp_nxt = `CPEC_RESP_SLVERR;
						end
					endcase
				end
			end
			WR_RESP: begin
				if (bready) begin
					bvalid_nxt = 1'b0;
					wrSt_nxt   = WR_COLLECT;
				end
			end
			default: begin
				wrSt_nxt = WR_COLLECT;
			end
		endcase
		awready_nxt = (wrSt_nxt == WR_COLLECT) && !awHeld_nxt;
		wready_nxt  = (wrSt_nxt == WR_COLLECT) && !wHeld_nxt;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wrSt_r    <= WR_COLLECT;
			awHeld_r  <= 1'b0;
			wHeld_r   <= 1'b0;
			awAddr_r  <= 8'h00;
			wData_r   <= 32'h0;
			wStrb0_r  <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `CPEC_RESP_OKAY;
			run_r     <= 1'b0;
			clr_r     <= 1'b0;
			sel0_r    <= cpec_evt_e'(`CPEC_SEL_RST);
			sel1_r    <= cpec_evt_e'(`CPEC_SEL_RST);
			wrap_r    <= 2'h0;
		end else if (ce) begin
			wrSt_r    <= wrSt_nxt;
			awHeld_r  <= awHeld_nxt;
			wHeld_r   <= wHeld_nxt;
			awAddr_r  <= awAddr_nxt;
			wData_r   <= wData_nxt;
			wStrb0_r  <= wStrb0_nxt;
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			run_r     <= run_nxt;
			clr_r     <= clr_nxt;
			sel0_r    <= sel0_nxt;
			sel1_r    <= sel1_nxt;
			wrap_r    <= wrap_nxt;
		end
	end

	// ==========================================
	// Read side: data registered one cycle after the address
	always_comb begin
		rdSt_nxt   = rdSt_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		case (rdSt_r)
			RD_IDLE: begin
				if (arvalid && arready_r) begin
					rvalid_nxt = 1'b1;
					rresp_nxt  = `CPEC_RESP_OKAY;
					rdSt_nxt   = RD_DATA;
					// Counts read live; stable only once stopped
					case (regIndex(araddr))
						IDX_CTRL: rdata_nxt = {31'h0, run_r};
						IDX_STAT: rdata_nxt = {29'h0, wrap_r, run_r};
						IDX_SEL0: rdata_nxt = {27'h0, sel0_r};
						IDX_SEL1: rdata_nxt = {27'h0, sel1_r};
						IDX_CNT0: rdata_nxt = cnt0;
						IDX_CNT1: rdata_nxt = cnt1;
						default: begin
							rdata_nxt = 32'h0;
							rresp_nxt = `CPEC_RESP_SLVERR;
						end
					endcase
				end
			end
			RD_DATA: begin
				if (rready) begin
					rvalid_nxt = 1'b0;
					rdSt_nxt   = RD_IDLE;
				end
			end
			default: begin
				rdSt_nxt = RD_IDLE;
			end
		endcase
		arready_nxt = (rdSt_nxt == RD_IDLE);
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rdSt_r    <= RD_IDLE;
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0;
			rresp_r   <= `CPEC_RESP_OKAY;
		end else if (ce) begin
			rdSt_r    <= rdSt_nxt;
			arready_r <= arready_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
		end
	end

	// ==========================================
	// Two independent channels sharing one event vector
	cpec_chan u_chan0 (
		.mclk      (mclk),
		.rstn      (rstn),
		.ce        (ce),
		.evtVec    (evt_r),
		.sel       (sel0_r),
		.run       (run_r),
		.clr       (clr_r),
		.count_r   (cnt0),
		.wrapHit_r (wrapHit0)
	);
	cpec_chan u_chan1 (
		.mclk      (mclk),
		.rstn      (rstn),
		.ce        (ce),
		.evtVec    (evt_r),
		.sel       (sel1_r),
		.run       (run_r),
		.clr       (clr_r),
		.count_r   (cnt1),
		.wrapHit_r (wrapHit1)
	);

	// Outputs, all from flip-flops
	assign awready       = awready_r;
	assign wready        = wready_r;
	assign bvalid        = bvalid_r;
	assign bresp         = bresp_r;
	assign arready       = arready_r;
	assign rvalid        = rvalid_r;
	assign rdata         = rdata_r;
	assign rresp         = rresp_r;
	assign measureActive = run_r;

	// ==========================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	a_cached_read: assert property (
		ce && opAccess && !opWrite && opCacheable && cacheEnable
		|=> evt_r[CACHED_OPERAND_READ_EVT] && !evt_r[CACHED_OPERAND_WRITE_EVT])
		else $error("Cached read not flagged");
	a_any_operand: assert property (
		ce |=> evt_r[ANY_OPERAND_ACCESS_EVT] == $past(opAccess))
		else $error("Operand access event wrong");
	a_dcache_any: assert property (
		ce |=> evt_r[DATA_CACHE_ANY_MISS_EVT] == ($past(dcReadMiss) || $past(dcWriteMiss)))
		else $error("Data cache miss event wrong");
	a_branch_zero: assert property (
		ce && branchZeroDisp |=> !evt_r[BRANCH_ISSUE_EVT] && !evt_r[BRANCH_TAKEN_EVT])
		else $error("Zero displacement branch counted");
	a_elapsed_tick: assert property (
		ce && run_r && !clr_r && sel0_r == ELAPSED_CYCLES |=> cnt0 == $past(cnt0) + 32'h1)
		else $error("Elapsed count did not step");
	a_stop_hold: assert property (
		!run_r && !clr_r ##1 !run_r && !clr_r |=> $stable(cnt1))
		else $error("Channel moved while stopped");
	a_read_answer: assert property (
		ce && arvalid && arready |=> rvalid ##0 !arready)
		else $error("Read not answered next cycle");
	a_bresp_hold: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("Write response dropped");

	c_dual_count: cover property (run_r && sel1_r == DUAL_ISSUE_EVT && evt_r[DUAL_ISSUE_EVT]);
	c_wrap: cover property (wrapHit0);
	c_write_read: cover property (bvalid && bready ##[1:8] rvalid && rready);
	c_both_run: cover property (run_r && sel0_r != sel1_r && evt_r[sel0_r] && evt_r[sel1_r]);

endmodule

// file: testbench/cpec_core_model.sv
// Behavioural core side: pipeline, cache, translation and break strobes
// Assumes the bench seeds the random generator before reset is released
module cpec_core_model (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// Event strobes and levels, one bit each, bit order as the bench wires them
	output logic      [31:0] ev
);
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================
	// Random strobes
	// About one cycle in four per bit, so back-to-back pulses occur often;
	// bit 14 flags zero-displacement conditional branches at random
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ev <= 32'h0;
		end else begin
			ev <= $urandom & $urandom & 32'h3fff_ffff; // Top bits unused
		end
	end
endmodule

// file: testbench/cpec_top_tb.sv
// Self-checking bench of the two-channel event counter
// Assumes cpec_pkg, cpec_top and cpec_core_model are compiled first
`include "cpec_params.svh"

module cpec_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cpec_pkg::*;

	logic        mclk = 1'b0, rstn = 1'b0, ce = 1'b1;
	logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, ev, evReg = 32'h0;
	logic        awready, wready, bvalid, arready, rvalid, measureActive;
	logic [1:0]  bresp, rresp;
	cpec_word_t  rdata;
	int          errors = 0, checks = 0, cyc = 0;
	int unsigned mdl [2] = '{0, 0};
	logic [4:0]  selMdl [2] = '{5'h1f, 5'h1f};

	// ==========================================
	// Clock, core model and design
	always #50 mclk = ~mclk;

	cpec_core_model cpec_core_model_inst (.mclk(mclk), .rstn(rstn), .ev(ev));

	cpec_top cpec_top_inst (.mclk(mclk), .rstn(rstn), .ce(ce),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.cacheEnable(ev[0]), .opAccess(ev[1]), .opWrite(ev[2]), .opCacheable(ev[3]),
		.opOnchipRam(ev[4]), .opPeriph(ev[5]), .dcReadMiss(ev[6]), .dcWriteMiss(ev[7]),
		.dataXlateMiss(ev[8]), .icacheMiss(ev[9]), .instrXlateMiss(ev[10]),
		.fetchAccept(ev[11]), .fetchCacheable(ev[12]), .branchIssue(ev[13]),
		.branchZeroDisp(ev[14]), .branchTaken(ev[15]), .callIssue(ev[16]),
		.instrIssue(ev[17]), .dualIssue(ev[18]), .floatIssue(ev[19]), .trapExec(ev[20]),
		.irqAccept(ev[21]), .nmiAccept(ev[22]), .breakMatchFirst(ev[23]),
		.breakMatchSecond(ev[24]), .icacheFill(ev[25]), .dcacheFill(ev[26]),
		.stallIcache(ev[27]), .stallDcache(ev[28]), .stallBranchExc(ev[29]),
		.measureActive(measureActive));

	// ==========================================
	// Reference model of event selection
	function automatic logic evtOf(input logic [31:0] e, input logic [4:0] k);
		case (k)
			5'h00: return e[1] & e[0] & e[3] & ~e[2];
			5'h01: return e[1] & e[0] & e[3] & e[2];
			5'h02: return e[1] & e[0] & e[3];
			5'h03: return e[1] & e[4];
			5'h04: return e[1];
			5'h05: return e[1] & e[5];
			5'h06, 5'h07, 5'h09: return e[k];
			5'h08: return e[6] | e[7];
			5'h0a: return e[8];
			5'h0b: return e[10];
			5'h0c: return e[11] & e[12] & e[0];
			5'h0d: return e[11];
			5'h0e: return e[13] & ~e[14];
			5'h0f: return e[15] & ~e[14];
			5'h1b: return 1'b1;
			5'h1c, 5'h1d, 5'h1e: return e[k - 5'h1];
			5'h1f: return 1'b0;
			default: return e[k];
		endcase
	endfunction

	// Counts step two edges after the strobe, only while the run flag stands
	// An edge with the clock enable low moves nothing, event stage included
	always @(posedge mclk) begin
		cyc++;
		if (ce === 1'b1) begin
			for (int c = 0; c < 2; c++) begin
				if (measureActive === 1'b1) mdl[c] += evtOf(evReg, selMdl[c]);
			end
			evReg = ev;
		end
		if (cyc == 30000) begin
			errors++;
			$display("ERROR %0t timeout", $time);
			conclude();
		end
	end

	// ==========================================
	// Compare and bus tasks
	task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t word got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t resp got %h exp %h", $time, got, exp);
		end
	endtask

	// Address and data offered together, each dropped once taken
	// Waits as long as the answer takes; only the bench timeout ends a hang
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chkResp(bresp, er);
		@(posedge mclk); // Gap so bready is never driven twice in one step
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [1:0] er, input logic [31:0] exp);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chkResp(rresp, er);
		chkWord(rdata, exp);
		@(posedge mclk);
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(32'h9a97e45c));
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		repeat (2) @(posedge mclk);
		// Reset values; selects come up on the idle code
		for (int i = 0; i < 6; i++) rdChk(8'(4 * i), 2'h0, (i / 2 == 1) ? 32'h1f : 32'h0);
		$display("test reset done");
		// Unmapped, unaligned and read-only places
		wr(8'h40, 32'h1, `CPEC_RESP_SLVERR);
		rdChk(8'h40, `CPEC_RESP_SLVERR, 32'h0);
		wr(8'h09, 32'h3, `CPEC_RESP_SLVERR);
		wr(`CPEC_OFF_CNT0, 32'h1234, `CPEC_RESP_OKAY);
		rdChk(`CPEC_OFF_CNT0, `CPEC_RESP_OKAY, 32'h0);
		$display("test refusal done");
		// Every event code except the idle 5'h1f on channel 0, its mirror on channel 1
		for (int k = 0; k < 31; k++) begin
			selMdl[0] = 5'(k);
			selMdl[1] = 5'(30 - k);
			wr(`CPEC_OFF_SEL0, 32'(k), 2'h0);
			wr(`CPEC_OFF_SEL1, 32'(30 - k), 2'h0);
			rdChk(`CPEC_OFF_SEL1, 2'h0, 32'(30 - k));
			wr(`CPEC_OFF_CTRL, 32'h2, 2'h0);
			mdl[0] = 0;
			mdl[1] = 0;
			rdChk(`CPEC_OFF_CNT1, 2'h0, 32'h0);
			wr(`CPEC_OFF_CTRL, 32'h1, 2'h0);
			chkWord({31'h0, measureActive}, 32'h1);
			rdChk(`CPEC_OFF_STAT, 2'h0, 32'h1);
			// Random clock-enable drops while counting; bus traffic only with it high
			repeat (20 + $urandom_range(40)) begin
				@(posedge mclk);
				ce <= ($urandom_range(3) != 0);
			end
			ce <= 1'b1;
			wr(`CPEC_OFF_CTRL, 32'h0, 2'h0);
			chkWord({31'h0, measureActive}, 32'h0);
			rdChk(`CPEC_OFF_CNT0, 2'h0, mdl[0]);
			rdChk(`CPEC_OFF_CNT1, 2'h0, mdl[1]);
			repeat (5) @(posedge mclk);
			rdChk(`CPEC_OFF_CNT0, 2'h0, mdl[0]);
			$display("test select %0d done", k);
		end
		conclude();
	end
endmodule
